// ===== design/l2at_table.sv
`default_nettype none
`include "l2at_consts.svh"

// Operation
// RQ1: egress ports come from destination address lookup in the table.
// RQ2: source addresses of received frames insert or refresh dynamic entries.
// RQ3: dynamic entry removed once unseen for the configured age time.
// RQ4: age time accepts 10 to 10000000 seconds, resets to 300.
// RQ5: aging can be switched off; then nothing expires.
// RQ6: auto mode learns unknown source addresses at once.
// RQ7: disabled mode adds no new entries.
// RQ8: secure mode passes only frames whose source matches a static entry.
// RQ9: a locked port ignores management writes to its learning mode.
// RQ10: up to 64 static entries with port bitmap, never aged.
// RQ11: table holds 8192 entries, ordered by VLAN then address.
// RQ12: each entry carries a static flag, reported on read.
// RQ13: lookup returns exact match or next entry in table order.
// RQ14: get-next keys on last returned pair; end-of-table when none.
// RQ15: destination miss floods VLAN members except the ingress port.
// RQ16: aging uses a one-second tick and a continuous sweep.
module l2at_table #(
    parameter int unsigned DEPTH = `L2AT_DEPTH,
    parameter int unsigned CYC_PER_SEC = `L2AT_SEC_NS / `L2AT_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic frm_valid,
    output logic frm_ready,
    input wire l2at_pkg::l2at_frame_t frm,
    output logic fwd_valid,
    output logic fwd_drop,
    output l2at_pkg::l2at_pmask_t fwd_ports,
    input wire logic mg_valid,
    output logic mg_ready,
    input wire l2at_pkg::l2at_mreq_t mg_req,
    output logic mg_rsp_valid,
    output l2at_pkg::l2at_mrsp_t mg_rsp,
    input wire logic age_wr,
    input wire logic [23:0] age_wr_secs,
    output logic [23:0] age_secs,
    input wire logic aging_off,
    input wire logic lmode_wr,
    input wire logic [`L2AT_PIDX_W-1:0] lmode_wr_port,
    input wire l2at_pkg::l2at_lmode_t lmode_wr_val,
    input wire l2at_pkg::l2at_pmask_t lmode_lock,
    output logic [6:0] static_count
);
    localparam int IW = $clog2(DEPTH);

    function automatic logic [23:0] clamp_age(input logic [23:0] s);
        if (s < `L2AT_AGE_MIN) begin
            clamp_age = `L2AT_AGE_MIN;
        end else if (s > `L2AT_AGE_MAX) begin
            clamp_age = `L2AT_AGE_MAX;
        end else begin
            clamp_age = s;
        end
    endfunction

    function automatic logic [59:0] key_of(input l2at_pkg::l2at_entry_t e);
        key_of = {e.vid, e.mac};
    endfunction

    // ****************************************************************
    // storage and state
    // ****************************************************************
    l2at_pkg::l2at_entry_t tbl [DEPTH];
    logic [DEPTH-1:0] vld_q;
    l2at_pkg::l2at_state_t state_q;
    l2at_pkg::l2at_lmode_t lmode_q [`L2AT_NPORT];
    l2at_pkg::l2at_frame_t frm_q;
    l2at_pkg::l2at_mreq_t req_q;
    logic [IW-1:0] scan_q, age_ptr_q, aidx_q, bidx_q, free_q, best_q;
    logic [59:0] key_a_q, key_b_q, best_key_q, last_key_q;
    logic ahit_q, bhit_q, bstat_q, free_v_q, best_v_q;
    logic [23:0] age_q;
    logic [6:0] st_cnt_q;
    logic tick;
    logic [23:0] now;

    l2at_sec_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .now(now)
    );

    assign frm_ready = (state_q == l2at_pkg::L2AT_IDLE);
    assign mg_ready = (state_q == l2at_pkg::L2AT_IDLE) && !frm_valid;
    assign age_secs = age_q;
    assign static_count = st_cnt_q;

    // ****************************************************************
    // configuration
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            age_q <= `L2AT_AGE_DEF; // RQ4
        end else if (age_wr) begin
            age_q <= clamp_age(age_wr_secs); // RQ4
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `L2AT_NPORT; i++) begin
                lmode_q[i] <= l2at_pkg::L2AT_LM_AUTO;
            end
        end else if (lmode_wr && lmode_wr_port < `L2AT_PIDX_W'(`L2AT_NPORT) && !lmode_lock[lmode_wr_port]) begin
            lmode_q[lmode_wr_port] <= lmode_wr_val; // RQ9
        end
    end

    // ****************************************************************
    // sequencing
    // ****************************************************************
    logic frm_ready_src_q;
    logic scan_last;
    assign scan_last = (scan_q == IW'(DEPTH - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= l2at_pkg::L2AT_IDLE;
            frm_q <= '0;
            req_q <= '0;
        end else begin
            unique case (state_q)
                l2at_pkg::L2AT_IDLE: begin
                    if (frm_valid) begin
                        frm_q <= frm;
                        req_q.op <= l2at_pkg::L2AT_OP_LOOKUP;
                        state_q <= l2at_pkg::L2AT_SCAN;
                    end else if (mg_valid) begin
                        req_q <= mg_req;
                        state_q <= l2at_pkg::L2AT_SCAN;
                    end
                end
                l2at_pkg::L2AT_SCAN: begin
                    if (scan_last) begin
                        state_q <= (frm_ready_src_q) ? l2at_pkg::L2AT_FEND : l2at_pkg::L2AT_MEND;
                    end
                end
                l2at_pkg::L2AT_FEND, l2at_pkg::L2AT_MEND: begin
                    state_q <= l2at_pkg::L2AT_IDLE;
                end
                default: begin
                    state_q <= l2at_pkg::L2AT_IDLE;
                end
            endcase
        end
    end

    // marks whether the current scan serves a frame or a management request
    always_ff @(posedge clk) begin
        if (rst) begin
            frm_ready_src_q <= 1'b0;
        end else if (state_q == l2at_pkg::L2AT_IDLE) begin
            frm_ready_src_q <= frm_valid;
        end
    end

    // ****************************************************************
    // full-table scan
    // ****************************************************************
    l2at_pkg::l2at_entry_t cur;
    logic [59:0] ckey;
    logic past_key;
    assign cur = tbl[scan_q];
    assign ckey = key_of(cur);
    assign past_key = (req_q.op == l2at_pkg::L2AT_OP_NEXT) ? (ckey > key_a_q) : (ckey >= key_a_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            scan_q <= '0;
            {ahit_q, bhit_q, bstat_q, free_v_q, best_v_q} <= 5'h00;
            {aidx_q, bidx_q, free_q, best_q} <= '0;
            {key_a_q, key_b_q, best_key_q} <= '0;
        end else if (state_q == l2at_pkg::L2AT_IDLE) begin
            scan_q <= '0;
            {ahit_q, bhit_q, bstat_q, free_v_q, best_v_q} <= 5'h00;
            if (frm_valid) begin
                key_a_q <= {frm.vid, frm.dest_hw_address}; // RQ1
                key_b_q <= {frm.vid, frm.src_hw_address}; // RQ2
            end else begin
                key_a_q <= (mg_req.op == l2at_pkg::L2AT_OP_NEXT) ? last_key_q : {mg_req.vid, mg_req.mac}; // RQ14
                key_b_q <= {mg_req.vid, mg_req.mac};
            end
        end else if (state_q == l2at_pkg::L2AT_SCAN) begin
            scan_q <= scan_q + IW'(1);
            if (vld_q[scan_q]) begin
                if (ckey == key_a_q) begin
                    ahit_q <= 1'b1;
                    aidx_q <= scan_q;
                end
                if (ckey == key_b_q) begin
                    bhit_q <= 1'b1;
                    bstat_q <= cur.is_static;
                    bidx_q <= scan_q;
                end
                if (past_key && (!best_v_q || ckey < best_key_q)) begin
                    best_v_q <= 1'b1; // RQ13
                    best_q <= scan_q;
                    best_key_q <= ckey; // RQ11
                end
            end else if (!free_v_q) begin
                free_v_q <= 1'b1;
                free_q <= scan_q;
            end
        end
    end

    // ****************************************************************
    // end-of-scan decisions
    // ****************************************************************
    l2at_pkg::l2at_lmode_t fmode;
    l2at_pkg::l2at_pmask_t src_oh;
    l2at_pkg::l2at_entry_t age_ent, best_ent;
    logic f_drop, wr_en, set_en, clr_en, st_inc, st_dec, m_ok, expire;
    logic [IW-1:0] wr_idx, clr_idx;
    l2at_pkg::l2at_entry_t wr_ent;
    logic st_add, st_room;

    assign fmode = lmode_q[frm_q.port];
    assign src_oh = l2at_pkg::l2at_pmask_t'(1) << frm_q.port;
    assign f_drop = (fmode == l2at_pkg::L2AT_LM_SECURE) && !(bhit_q && bstat_q); // RQ8
    assign age_ent = tbl[age_ptr_q];
    assign best_ent = tbl[best_q];
    assign st_add = (req_q.op == l2at_pkg::L2AT_OP_ST_ADD);
    assign st_room = (st_cnt_q < 7'(`L2AT_STATIC_MAX));

    // sweep runs only while idle so it never races a scan
    assign expire = (state_q == l2at_pkg::L2AT_IDLE) && !aging_off && vld_q[age_ptr_q] && !age_ent.is_static
        && ((now - age_ent.stamp) >= age_q); // RQ3 RQ5 RQ10 RQ16

    always_comb begin
        wr_en = 1'b0;
        set_en = 1'b0;
        clr_en = expire;
        clr_idx = age_ptr_q;
        wr_idx = bidx_q;
        wr_ent = '{is_static: 1'b0, vid: key_b_q[59:48], mac: key_b_q[47:0], ports: src_oh, stamp: now};
        st_inc = 1'b0;
        st_dec = 1'b0;
        m_ok = 1'b1;
        if (state_q == l2at_pkg::L2AT_FEND) begin
            if (bhit_q && !bstat_q && fmode != l2at_pkg::L2AT_LM_SECURE) begin
                wr_en = 1'b1; // RQ2
            end else if (!bhit_q && fmode == l2at_pkg::L2AT_LM_AUTO && free_v_q) begin
                wr_en = 1'b1; // RQ6 RQ7
                set_en = 1'b1;
                wr_idx = free_q;
            end
        end else if (state_q == l2at_pkg::L2AT_MEND && st_add) begin
            wr_ent.is_static = 1'b1; // RQ10 RQ12
            wr_ent.ports = req_q.ports;
            if (bhit_q && (bstat_q || st_room)) begin
                wr_en = 1'b1;
                st_inc = !bstat_q;
            end else if (!bhit_q && free_v_q && st_room) begin
                wr_en = 1'b1;
                set_en = 1'b1;
                wr_idx = free_q;
                st_inc = 1'b1;
            end else begin
                m_ok = 1'b0;
            end
        end else if (state_q == l2at_pkg::L2AT_MEND && req_q.op == l2at_pkg::L2AT_OP_ST_DEL) begin
            clr_en = bhit_q && bstat_q;
            clr_idx = bidx_q;
            st_dec = bhit_q && bstat_q;
            m_ok = bhit_q && bstat_q;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            tbl[wr_idx] <= wr_ent;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vld_q <= '0;
        end else begin
            if (clr_en) begin
                vld_q[clr_idx] <= 1'b0; // RQ3
            end
            if (set_en) begin
                vld_q[wr_idx] <= 1'b1; // RQ11
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            age_ptr_q <= '0;
        end else if (state_q == l2at_pkg::L2AT_IDLE) begin
            age_ptr_q <= age_ptr_q + IW'(1); // RQ16
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_cnt_q <= 7'h00;
        end else if (st_inc) begin
            st_cnt_q <= st_cnt_q + 7'h01; // RQ10
        end else if (st_dec) begin
            st_cnt_q <= st_cnt_q - 7'h01;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            fwd_valid <= 1'b0;
            fwd_drop <= 1'b0;
            fwd_ports <= '0;
        end else begin
            fwd_valid <= (state_q == l2at_pkg::L2AT_FEND);
            if (state_q == l2at_pkg::L2AT_FEND) begin
                fwd_drop <= f_drop;
                if (f_drop) begin
                    fwd_ports <= '0;
                end else if (ahit_q) begin
                    fwd_ports <= tbl[aidx_q].ports & ~src_oh; // RQ1
                end else begin
                    fwd_ports <= frm_q.vlan_ports & ~src_oh; // RQ15
                end
            end
        end
    end

    logic m_lookup;
    assign m_lookup = (req_q.op == l2at_pkg::L2AT_OP_LOOKUP) || (req_q.op == l2at_pkg::L2AT_OP_NEXT);

    always_ff @(posedge clk) begin
        if (rst) begin
            mg_rsp_valid <= 1'b0;
            mg_rsp <= '0;
            last_key_q <= '0;
        end else begin
            mg_rsp_valid <= (state_q == l2at_pkg::L2AT_MEND);
            if (state_q == l2at_pkg::L2AT_MEND) begin
                if (m_lookup) begin
                    mg_rsp.ok <= best_v_q;
                    mg_rsp.eot <= !best_v_q; // RQ14
                    mg_rsp.is_static <= best_v_q && best_ent.is_static; // RQ12
                    mg_rsp.vid <= best_v_q ? best_ent.vid : 12'h000;
                    mg_rsp.mac <= best_v_q ? best_ent.mac : 48'h0;
                    mg_rsp.ports <= best_v_q ? best_ent.ports : '0;
                    if (best_v_q) begin
                        last_key_q <= best_key_q; // RQ14
                    end
                end else begin
                    mg_rsp <= '{ok: m_ok, eot: 1'b0, is_static: st_add, vid: req_q.vid, mac: req_q.mac,
                        ports: req_q.ports};
                end
            end
        end
    end
endmodule // l2at_table
`default_nettype wire

// ===== design/l2at_consts.svh
`ifndef L2AT_CONSTS_SVH
`define L2AT_CONSTS_SVH

// ****************************************************************
// table sizes
// ****************************************************************
`define L2AT_DEPTH 8192
`define L2AT_STATIC_MAX 64
`define L2AT_NPORT 20
`define L2AT_PIDX_W 5

// ****************************************************************
// timing
// ****************************************************************
`define L2AT_CLK_NS 10
`define L2AT_SEC_NS 1000000000
`define L2AT_AGE_DEF 24'h00012C
`define L2AT_AGE_MIN 24'h00000A
`define L2AT_AGE_MAX 24'h989680

`endif

// ===== design/l2at_pkg.sv
`default_nettype none
`include "l2at_consts.svh"

package l2at_pkg;

    typedef logic [`L2AT_NPORT-1:0] l2at_pmask_t;

    typedef enum logic [1:0] {
        L2AT_LM_AUTO = 2'h0,
        L2AT_LM_OFF = 2'h1,
        L2AT_LM_SECURE = 2'h2
    } l2at_lmode_t;

    typedef enum logic [1:0] {
        L2AT_OP_LOOKUP = 2'h0,
        L2AT_OP_NEXT = 2'h1,
        L2AT_OP_ST_ADD = 2'h2,
        L2AT_OP_ST_DEL = 2'h3
    } l2at_op_t;

    typedef enum logic [3:0] {
        L2AT_IDLE = 4'h1,
        L2AT_SCAN = 4'h2,
        L2AT_FEND = 4'h4,
        L2AT_MEND = 4'h8
    } l2at_state_t;

    typedef struct packed {
        logic is_static;
        logic [11:0] vid;
        logic [47:0] mac;
        l2at_pmask_t ports;
        logic [23:0] stamp;
    } l2at_entry_t;

    typedef struct packed {
        logic [11:0] vid;
        logic [47:0] dest_hw_address;
        logic [47:0] src_hw_address;
        logic [`L2AT_PIDX_W-1:0] port;
        l2at_pmask_t vlan_ports;
    } l2at_frame_t;

    typedef struct packed {
        l2at_op_t op;
        logic [11:0] vid;
        logic [47:0] mac;
        l2at_pmask_t ports;
    } l2at_mreq_t;

    typedef struct packed {
        logic ok;
        logic eot;
        logic is_static;
        logic [11:0] vid;
        logic [47:0] mac;
        l2at_pmask_t ports;
    } l2at_mrsp_t;

endpackage
`default_nettype wire

// ===== design/l2at_sec_tick.sv
`default_nettype none
`include "l2at_consts.svh"

module l2at_sec_tick #(
    parameter int unsigned CYC_PER_SEC = `L2AT_SEC_NS / `L2AT_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick,
    output logic [23:0] now
);
    logic [31:0] cnt_q;
    logic tick_q;
    logic [23:0] now_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(CYC_PER_SEC - 1)) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // seconds counter wraps; differences stay valid since age max is below 2^24
    always_ff @(posedge clk) begin
        if (rst) begin
            now_q <= 24'h0;
        end else if (tick_q) begin
            now_q <= now_q + 24'h1;
        end
    end

    assign tick = tick_q;
    assign now = now_q;
endmodule // l2at_sec_tick
`default_nettype wire

// ===== testbench/l2at_monitor.sv
`default_nettype none

module l2at_monitor #(
    parameter int unsigned DEPTH = 8192
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic frm_valid,
    input wire logic frm_ready,
    input wire l2at_pkg::l2at_frame_t frm,
    input wire logic fwd_valid,
    input wire logic fwd_drop,
    input wire l2at_pkg::l2at_pmask_t fwd_ports,
    input wire logic mg_valid,
    input wire logic mg_ready,
    input wire logic mg_rsp_valid,
    input wire l2at_pkg::l2at_mrsp_t mg_rsp,
    input wire logic age_wr,
    input wire logic [23:0] age_secs,
    input wire logic [6:0] static_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // request latency counter
    // ********************************
    localparam int unsigned LAT = DEPTH + 2;
    logic busy_q;
    logic is_mg_q;
    int unsigned cnt_q;
    logic [4:0] port_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            is_mg_q <= 1'b0;
            cnt_q <= 0;
            port_q <= 5'h00;
        end else if ((frm_valid && frm_ready) || (mg_valid && mg_ready)) begin
            busy_q <= 1'b1;
            cnt_q <= 1;
            is_mg_q <= !(frm_valid && frm_ready);
            port_q <= frm.port;
        end else if (busy_q && cnt_q == LAT) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    fwd_time_a: assert property (fwd_valid |-> busy_q && !is_mg_q && cnt_q == LAT)
        else $error("forward result at wrong cycle");
    fwd_due_a: assert property (busy_q && !is_mg_q && cnt_q == LAT |-> fwd_valid)
        else $error("forward result missing");
    mg_time_a: assert property (mg_rsp_valid |-> busy_q && is_mg_q && cnt_q == LAT)
        else $error("management answer at wrong cycle");
    mg_due_a: assert property (busy_q && is_mg_q && cnt_q == LAT |-> mg_rsp_valid)
        else $error("management answer missing");
    busy_refuse_a: assert property (busy_q && cnt_q != LAT |-> !frm_ready && !mg_ready)
        else $error("request accepted while busy");
    frame_first_a: assert property (frm_valid |-> !mg_ready)
        else $error("management taken over pending frame");
    drop_empty_a: assert property (fwd_valid && fwd_drop |-> fwd_ports == '0)
        else $error("dropped frame has egress ports");
    no_echo_a: assert property (fwd_valid |-> !fwd_ports[port_q])
        else $error("frame sent back to ingress port");
    age_range_a: assert property (age_wr |=> age_secs >= 24'h00000A && age_secs <= 24'h989680)
        else $error("age time out of range");
    age_default_a: assert property ($fell(rst) |-> age_secs == 24'h00012C)
        else $error("age time not default after reset");
    eot_clear_a: assert property (mg_rsp_valid && mg_rsp.eot |-> !mg_rsp.ok && mg_rsp.vid == 12'h000
        && mg_rsp.mac == 48'h0)
        else $error("end of table answer not cleared");
    static_cap_a: assert property (static_count <= 7'h40)
        else $error("too many static entries");
endmodule // l2at_monitor

bind l2at_table l2at_monitor #(.DEPTH(DEPTH)) l2at_monitor_i (.clk, .rst, .frm_valid, .frm_ready, .frm,
    .fwd_valid, .fwd_drop, .fwd_ports, .mg_valid, .mg_ready, .mg_rsp_valid, .mg_rsp, .age_wr, .age_secs,
    .static_count);

`default_nettype wire

// ===== testbench/l2at_pipe_model.sv
`default_nettype none

module l2at_pipe_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire l2at_pkg::l2at_frame_t f_in,
    output logic frm_valid,
    output l2at_pkg::l2at_frame_t frm,
    input wire logic frm_ready,
    input wire logic fwd_valid,
    input wire logic fwd_drop,
    input wire l2at_pkg::l2at_pmask_t fwd_ports,
    output logic done,
    output l2at_pkg::l2at_pmask_t got_ports,
    output logic got_drop
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // hold frame until taken, collect verdict
    // ********************************
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            frm_valid <= 1'b0;
            frm <= '0;
            got_ports <= '0;
            got_drop <= 1'b0;
        end else begin
            if (send) begin
                frm_valid <= 1'b1;
                frm <= f_in;
            end else if (frm_valid && frm_ready) begin
                // released lines no longer show the frame
                frm_valid <= 1'b0;
                frm <= ~frm;
            end
            if (fwd_valid) begin
                done <= 1'b1;
                got_ports <= fwd_ports;
                got_drop <= fwd_drop;
            end
        end
    end
endmodule // l2at_pipe_model

`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned DEPTH = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic send, done, got_drop, frm_valid, frm_ready, fwd_valid, fwd_drop;
    logic mg_valid, mg_ready, mg_rsp_valid, age_wr, aging_off, lmode_wr;
    l2at_pkg::l2at_frame_t f_in, frm;
    l2at_pkg::l2at_pmask_t fwd_ports, got_ports, lmode_lock;
    l2at_pkg::l2at_mreq_t mg_req;
    l2at_pkg::l2at_mrsp_t mg_rsp, r;
    l2at_pkg::l2at_lmode_t lmode_wr_val;
    logic [23:0] age_wr_secs, age_secs;
    logic [4:0] lmode_wr_port;
    logic [6:0] static_count;
    int n_errors = 0;
    int compares = 0;

    always #5 clk = ~clk;

    l2at_table #(.DEPTH(DEPTH), .CYC_PER_SEC(20)) l2at_table_i (.clk, .rst, .frm_valid, .frm_ready, .frm,
        .fwd_valid, .fwd_drop, .fwd_ports, .mg_valid, .mg_ready, .mg_req, .mg_rsp_valid, .mg_rsp, .age_wr,
        .age_wr_secs, .age_secs, .aging_off, .lmode_wr, .lmode_wr_port, .lmode_wr_val, .lmode_lock,
        .static_count);
    l2at_pipe_model l2at_pipe_model_i (.clk, .rst, .send, .f_in, .frm_valid, .frm, .frm_ready, .fwd_valid,
        .fwd_drop, .fwd_ports, .done, .got_ports, .got_drop);

    // ********************************
    // shared tasks
    // ********************************
    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic guard(input int i);
        if (i >= 100) begin
            chk(64'h0, 64'h1);
            print_verdict();
        end
    endtask

    task automatic mg(input l2at_pkg::l2at_op_t op, input logic [11:0] vid, input logic [47:0] mac,
        input logic [19:0] pm);
        int i;
        mg_req = '{op, vid, mac, pm};
        mg_valid = 1'b1;
        for (i = 0; mg_ready !== 1'b1 && i < 100; i++) tick(1);
        guard(i);
        tick(1);
        mg_valid = 1'b0;
        for (i = 0; mg_rsp_valid !== 1'b1 && i < 100; i++) tick(1);
        guard(i);
        r = mg_rsp;
    endtask

    task automatic fr(input logic [11:0] vid, input logic [47:0] dst, input logic [47:0] src,
        input logic [4:0] port, input logic [19:0] vp);
        int i;
        f_in = '{vid, dst, src, port, vp};
        send = 1'b1;
        tick(1);
        send = 1'b0;
        for (i = 0; done !== 1'b1 && i < 100; i++) tick(1);
        guard(i);
    endtask

    task automatic lm(input logic [4:0] p, input l2at_pkg::l2at_lmode_t v);
        lmode_wr_port = p;
        lmode_wr_val = v;
        lmode_wr = 1'b1;
        tick(1);
        lmode_wr = 1'b0;
    endtask

    task automatic age(input logic [23:0] v, input logic [23:0] exp);
        age_wr_secs = v;
        age_wr = 1'b1;
        tick(1);
        age_wr = 1'b0;
        tick(1);
        chk(age_secs, exp);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        chk(age_secs, 24'h00012C);
        chk(static_count, 7'h00);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h000, 48'h0, 20'h0);
        chk({r.eot, r.ok}, 2'b10);
        $display("t_reset done");
    endtask

    task automatic t_learn();
        fr(12'h001, 48'h999, 48'h100, 5'h01, 20'h0000F);
        chk({got_drop, got_ports}, {1'b0, 20'h0000D});
        fr(12'h001, 48'h100, 48'h080, 5'h03, 20'h0000F);
        chk(got_ports, 20'h00002);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h001, 48'h100, 20'h0);
        chk({r.ok, r.is_static, r.mac}, {1'b1, 1'b0, 48'h100});
        chk(r.ports, 20'h00002);
        $display("t_learn done");
    endtask

    task automatic t_order();
        mg(l2at_pkg::L2AT_OP_ST_ADD, 12'h002, 48'h050, 20'h00030);
        chk(r.ok, 1'b1);
        chk(static_count, 7'h01);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h000, 48'h0, 20'h0);
        chk({r.vid, r.mac}, {12'h001, 48'h080});
        mg(l2at_pkg::L2AT_OP_NEXT, 12'h000, 48'h0, 20'h0);
        chk({r.vid, r.mac}, {12'h001, 48'h100});
        mg(l2at_pkg::L2AT_OP_NEXT, 12'h000, 48'h0, 20'h0);
        chk({r.is_static, r.vid}, {1'b1, 12'h002});
        chk({r.mac, r.ports}, {48'h050, 20'h00030});
        mg(l2at_pkg::L2AT_OP_NEXT, 12'h000, 48'h0, 20'h0);
        chk(r.eot, 1'b1);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h001, 48'h081, 20'h0);
        chk(r.mac, 48'h100);
        $display("t_order done");
    endtask

    task automatic t_modes();
        lm(5'h04, l2at_pkg::L2AT_LM_OFF);
        fr(12'h001, 48'h999, 48'h200, 5'h04, 20'h0001F);
        chk(got_ports, 20'h0000F);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h001, 48'h200, 20'h0);
        chk(r.vid, 12'h002);
        lmode_lock = 20'h00010;
        lm(5'h04, l2at_pkg::L2AT_LM_AUTO);
        fr(12'h001, 48'h999, 48'h200, 5'h04, 20'h0001F);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h001, 48'h200, 20'h0);
        chk(r.vid, 12'h002);
        lmode_lock = 20'h00000;
        lm(5'h05, l2at_pkg::L2AT_LM_SECURE);
        fr(12'h002, 48'h999, 48'h077, 5'h05, 20'h000F0);
        chk({got_drop, got_ports}, {1'b1, 20'h00000});
        fr(12'h002, 48'h999, 48'h050, 5'h05, 20'h000F0);
        chk({got_drop, got_ports}, {1'b0, 20'h000D0});
        $display("t_modes done");
    endtask

    task automatic t_age();
        aging_off = 1'b1;
        age(24'h000005, 24'h00000A);
        age(24'hFFFFFF, 24'h989680);
        age(24'h00000A, 24'h00000A);
        tick(300);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h001, 48'h0, 20'h0);
        chk({r.vid, r.mac}, {12'h001, 48'h080});
        aging_off = 1'b0;
        tick(400);
        mg(l2at_pkg::L2AT_OP_LOOKUP, 12'h000, 48'h0, 20'h0);
        chk({r.vid, r.mac}, {12'h002, 48'h050});
        mg(l2at_pkg::L2AT_OP_ST_DEL, 12'h002, 48'h050, 20'h0);
        chk(r.ok, 1'b1);
        mg(l2at_pkg::L2AT_OP_ST_DEL, 12'h002, 48'h050, 20'h0);
        chk(r.ok, 1'b0);
        chk(static_count, 7'h00);
        $display("t_age done");
    endtask

    initial begin
        send = 1'b0;
        f_in = '0;
        mg_valid = 1'b0;
        mg_req = '0;
        age_wr = 1'b0;
        age_wr_secs = 24'h000000;
        aging_off = 1'b0;
        lmode_wr = 1'b0;
        lmode_wr_port = 5'h00;
        lmode_wr_val = l2at_pkg::L2AT_LM_AUTO;
        lmode_lock = 20'h00000;
        tick(6);
        rst = 1'b0;
        t_reset();
        t_learn();
        t_order();
        t_modes();
        t_age();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
